// ---- logic/pts_pkg.sv ----
package pts_pkg;

  localparam int unsigned NSTAGE = 8;
  localparam int unsigned NGROUP = 4;
  localparam int unsigned NMEAS  = 43;
  localparam int unsigned NVAI   = 5;
  localparam int unsigned NSIG   = 48;
  localparam int unsigned VW     = 16;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BASE_TICK_MS  = 10;
  localparam int unsigned BASE_TICK_CYC = BASE_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0]  SLOW_DIV_LAST = 4'h9;
  localparam logic [6:0]  PERIOD_10_MS  = 7'h0a;
  localparam logic [6:0]  PERIOD_20_MS  = 7'h14;
  localparam logic [6:0]  PERIOD_100_MS = 7'h64;

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_GROUP   = 12'h000;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h004;
  localparam logic [11:0] ADDR_IRQ_MSK = 12'h008;
  localparam logic [11:0] ADDR_STATE   = 12'h00c;
  localparam logic [11:0] SET_BASE     = 12'h100;
  localparam logic [11:0] SET_END      = 12'h500;
  localparam int unsigned SET_STRIDE_SH = 5;
  localparam logic [2:0]  W_CTRL  = 3'h0;
  localparam logic [2:0]  W_LIMIT = 3'h1;
  localparam logic [2:0]  W_HYST  = 3'h2;
  localparam logic [2:0]  W_DELAY = 3'h3;
  localparam logic [2:0]  W_FLOOR = 3'h4;

  // Control word fields
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_MODE  = 1;
  localparam int unsigned CTRL_PRIO  = 3;
  localparam int unsigned CTRL_SELA  = 8;
  localparam int unsigned CTRL_SELB  = 16;

  // Reset values
  localparam logic [1:0]  GROUP_RST  = 2'h0;
  localparam logic [15:0] MASK_RST   = 16'h0000;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] VAL_RST    = 16'h0000;
  localparam logic [31:0] DATA_ERR   = 32'h0000_0000;

  // Signals whose unit allows negative limits (powers, virtual analog inputs)
  localparam logic [NSIG-1:0] SIGNED_SIG = 48'hf800_00f0_3c00;

  typedef enum logic [1:0] {
    OVER_MODE                = 2'h0,
    UNDER_MODE               = 2'h1,
    DIFF_MODE                = 2'h3,
    ABSOLUTE_DIFFERENCE_MODE = 2'h2
  } pts_mode_t;

  typedef enum logic [1:0] {
    PRIO_10MS  = 2'h0,
    PRIO_20MS  = 2'h1,
    PRIO_100MS = 2'h3
  } pts_prio_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_STARTED = 2'h1,
    ST_TRIPPED = 2'h3
  } pts_state_t;

endpackage

// ---- logic/pts_top.sv ----
`timescale 1ns/100ps

// Operation
// - Over mode starts above the limit, under mode below it.
// - Difference modes use primary minus secondary signal.
// - Absolute-difference mode starts when the difference magnitude exceeds the limit.
// - Signed-difference mode starts only on a positive difference above the limit.
// - Limit range and unit follow the selected signal.
// - A definite-time delay separates start from operation.
// - Hysteresis dead band delays release past the limit.
// - The no-compare floor applies in under mode only.
// - In under mode, values below the floor are not faults.
// - Selectable signals include five virtual analog inputs.
// - Eight independent stages with own selection, mode, limit and timing.
// - Each stage has its own enable; disabled stages stay inactive.
// - Four setting groups; the active group feeds comparison.
// - Secondary selection is used only in difference modes.
// - Evaluation period selectable as 10, 20 or 100 ms.
module pts_top #(
  parameter int unsigned BASE_TICK_CYC = pts_pkg::BASE_TICK_CYC
) (
  input  wire logic                                       pclk,
  input  wire logic                                       presetn,
  input  wire logic                                       psel,
  input  wire logic                                       penable,
  input  wire logic                                       pwrite,
  input  wire logic [11:0]                                paddr,
  input  wire logic [31:0]                                pwdata,
  output logic      [31:0]                                prdata,
  output logic                                            pready,
  output logic                                            pslverr,
  input  wire logic [pts_pkg::NMEAS-1:0][pts_pkg::VW-1:0] meas_value,
  input  wire logic [pts_pkg::NVAI-1:0][pts_pkg::VW-1:0]  virtual_analog_input,
  output logic      [pts_pkg::NSTAGE-1:0]                 stage_start,
  output logic      [pts_pkg::NSTAGE-1:0]                 stage_trip,
  output logic                                            irq
);

  localparam int unsigned NS = pts_pkg::NSTAGE;
  localparam int unsigned NG = pts_pkg::NGROUP;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic signed [17:0] pick(input logic [5:0] sel,
                                              input logic [pts_pkg::NSIG-1:0][15:0] all);
    pick = (sel < 6'(pts_pkg::NSIG)) ? 18'(signed'(all[sel])) : 18'sh0;
  endfunction

  function automatic logic [6:0] period_ms(input logic [1:0] prio);
    case (prio)
      pts_pkg::PRIO_10MS:  period_ms = pts_pkg::PERIOD_10_MS;
      pts_pkg::PRIO_20MS:  period_ms = pts_pkg::PERIOD_20_MS;
      default:             period_ms = pts_pkg::PERIOD_100_MS;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Settings storage and APB slave
  logic [31:0] ctrl_r  [NS][NG];
  logic [15:0] limit_r [NS][NG];
  logic [15:0] hyst_r  [NS][NG];
  logic [15:0] delay_r [NS][NG];
  logic [15:0] floor_r [NS][NG];
  logic [1:0]  group_r;
  logic [15:0] mask_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        done;
  logic        set_hit;
  logic [4:0]  set_idx;
  logic [2:0]  set_w;
  logic [2:0]  s_sel;
  logic [1:0]  g_sel;
  logic [15:0] events;
  assign done    = psel & penable & pready_r;
  assign set_hit = (paddr >= pts_pkg::SET_BASE) && (paddr < pts_pkg::SET_END)
                   && (paddr[1:0] == 2'h0) && (paddr[4:2] <= pts_pkg::W_FLOOR);
  assign set_idx = 5'((paddr - pts_pkg::SET_BASE) >> pts_pkg::SET_STRIDE_SH);
  assign set_w   = paddr[4:2];
  assign s_sel   = set_idx[4:2];
  assign g_sel   = set_idx[1:0];
  always_comb begin
    pready_nxt  = psel & penable & ~pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    status_nxt  = status_r;
    if (psel & penable & ~pready_r) begin
      prdata_nxt = pts_pkg::DATA_ERR;
      if (set_hit) begin
        case (set_w)
          pts_pkg::W_CTRL:  prdata_nxt = ctrl_r[s_sel][g_sel];
          pts_pkg::W_LIMIT: prdata_nxt = {16'h0000, limit_r[s_sel][g_sel]};
          pts_pkg::W_HYST:  prdata_nxt = {16'h0000, hyst_r[s_sel][g_sel]};
          pts_pkg::W_DELAY: prdata_nxt = {16'h0000, delay_r[s_sel][g_sel]};
          default:          prdata_nxt = {16'h0000, floor_r[s_sel][g_sel]};
        endcase
      end else begin
        case (paddr)
          pts_pkg::ADDR_GROUP:   prdata_nxt = {30'h0, group_r};
          pts_pkg::ADDR_IRQ_ST:  prdata_nxt = {16'h0000, status_r};
          pts_pkg::ADDR_IRQ_MSK: prdata_nxt = {16'h0000, mask_r};
          pts_pkg::ADDR_STATE:   prdata_nxt = {16'h0000, stage_trip, stage_start};
          default:               pslverr_nxt = 1'b1;
        endcase
      end
    end
    // Read clears, but a new event in the same cycle survives
    if (done && !pwrite && paddr == pts_pkg::ADDR_IRQ_ST) begin
      status_nxt = 16'h0000;
    end
    status_nxt = status_nxt | events;
    irq_nxt    = |(status_nxt & ((done && pwrite && paddr == pts_pkg::ADDR_IRQ_MSK)
                                 ? pwdata[15:0] : mask_r));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= pts_pkg::DATA_ERR;
      status_r  <= 16'h0000;
      irq_r     <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      status_r  <= status_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Settings are written only at the completing edge of a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_r <= pts_pkg::GROUP_RST;
      mask_r  <= pts_pkg::MASK_RST;
      for (int s = 0; s < NS; s++) begin
        for (int g = 0; g < NG; g++) begin
          ctrl_r[s][g]  <= pts_pkg::CTRL_RST;
          limit_r[s][g] <= pts_pkg::VAL_RST;
          hyst_r[s][g]  <= pts_pkg::VAL_RST;
          delay_r[s][g] <= pts_pkg::VAL_RST;
          floor_r[s][g] <= pts_pkg::VAL_RST;
        end
      end
    end else if (done && pwrite) begin
      if (set_hit) begin
        case (set_w)
          pts_pkg::W_CTRL:  ctrl_r[s_sel][g_sel]  <= pwdata & 32'h003f_3f1f;
          pts_pkg::W_LIMIT: limit_r[s_sel][g_sel] <= pwdata[15:0];
          pts_pkg::W_HYST:  hyst_r[s_sel][g_sel]  <= pwdata[15:0];
          pts_pkg::W_DELAY: delay_r[s_sel][g_sel] <= pwdata[15:0];
          default:          floor_r[s_sel][g_sel] <= pwdata[15:0];
        endcase
      end else if (paddr == pts_pkg::ADDR_GROUP) begin
        group_r <= pwdata[1:0];
      end else if (paddr == pts_pkg::ADDR_IRQ_MSK) begin
        mask_r <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation period ticks
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic [3:0]  slow_r;
  logic [3:0]  slow_nxt;
  logic        base_tick;
  assign base_tick = (tick_cnt_r == 32'(BASE_TICK_CYC - 1));
  always_comb begin
    tick_cnt_nxt = base_tick ? 32'h0 : tick_cnt_r + 32'h1;
    slow_nxt     = slow_r;
    if (base_tick) begin
      slow_nxt = (slow_r == pts_pkg::SLOW_DIV_LAST) ? 4'h0 : slow_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
      slow_r     <= 4'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      slow_r     <= slow_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage comparison and timing
  logic [pts_pkg::NSIG-1:0][15:0] all_sig;
  pts_pkg::pts_state_t   state_r   [NS];
  pts_pkg::pts_state_t   state_nxt [NS];
  logic [15:0]           elap_r    [NS];
  logic [15:0]           elap_nxt  [NS];
  logic [NS-1:0]         start_r;
  logic [NS-1:0]         start_nxt;
  logic [NS-1:0]         trip_r;
  logic [NS-1:0]         trip_nxt;
  logic [NS-1:0]         en;
  logic [NS-1:0]         eval_now;
  logic [NS-1:0]         cond;
  pts_pkg::pts_mode_t    mode      [NS];
  logic signed [17:0]    va        [NS];
  logic signed [17:0]    vd        [NS];
  logic signed [17:0]    lim       [NS];
  logic signed [17:0]    hys       [NS];
  logic signed [17:0]    flo       [NS];
  assign all_sig = {virtual_analog_input, meas_value};
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      logic [31:0] c;
      logic [5:0]  sa;
      logic [5:0]  sb;
      logic [1:0]  pr;
      logic signed [17:0] mag;
      logic signed [17:0] thr;
      logic [16:0] acc;
      c   = ctrl_r[s][group_r];
      sa  = c[pts_pkg::CTRL_SELA +: 6];
      sb  = c[pts_pkg::CTRL_SELB +: 6];
      pr  = c[pts_pkg::CTRL_PRIO +: 2];
      en[s]   = c[pts_pkg::CTRL_EN];
      mode[s] = pts_pkg::pts_mode_t'(c[pts_pkg::CTRL_MODE +: 2]);
      eval_now[s] = base_tick && (pr == pts_pkg::PRIO_10MS
                    || (pr == pts_pkg::PRIO_20MS && !slow_r[0])
                    || (pr != pts_pkg::PRIO_10MS && pr != pts_pkg::PRIO_20MS
                        && slow_r == 4'h0));
      va[s]  = pick(sa, all_sig);
      vd[s]  = va[s] - pick(sb, all_sig);
      lim[s] = 18'(signed'(limit_r[s][group_r]));
      if (!pts_pkg::SIGNED_SIG[sa] && lim[s] < 18'sh0) begin
        lim[s] = 18'sh0;
      end
      hys[s] = 18'($unsigned(hyst_r[s][group_r]));
      flo[s] = 18'(signed'(floor_r[s][group_r]));
      thr    = (state_r[s] == pts_pkg::ST_IDLE) ? lim[s] : lim[s] - hys[s];
      mag    = (vd[s] < 18'sh0) ? -vd[s] : vd[s];
      case (mode[s])
        pts_pkg::OVER_MODE:  cond[s] = va[s] > thr;
        pts_pkg::UNDER_MODE: cond[s] = (va[s] >= flo[s]) &&
          (va[s] < ((state_r[s] == pts_pkg::ST_IDLE) ? lim[s] : lim[s] + hys[s]));
        pts_pkg::DIFF_MODE:  cond[s] = (vd[s] > 18'sh0) && (vd[s] > thr);
        default:             cond[s] = mag > thr;
      endcase
      state_nxt[s] = state_r[s];
      elap_nxt[s]  = elap_r[s];
      acc = 17'(elap_r[s]) + 17'(period_ms(pr));
      if (!en[s]) begin
        state_nxt[s] = pts_pkg::ST_IDLE;
        elap_nxt[s]  = 16'h0;
      end else if (eval_now[s]) begin
        case (state_r[s])
          pts_pkg::ST_IDLE: begin
            if (cond[s]) begin
              elap_nxt[s]  = 16'h0;
              state_nxt[s] = (delay_r[s][group_r] == 16'h0) ? pts_pkg::ST_TRIPPED
                                                            : pts_pkg::ST_STARTED;
            end
          end
          pts_pkg::ST_STARTED: begin
            if (!cond[s]) begin
              state_nxt[s] = pts_pkg::ST_IDLE;
            end else begin
              elap_nxt[s] = acc[16] ? 16'hffff : acc[15:0];
              if (acc >= 17'(delay_r[s][group_r])) begin
                state_nxt[s] = pts_pkg::ST_TRIPPED;
              end
            end
          end
          pts_pkg::ST_TRIPPED: begin
            if (!cond[s]) begin
              state_nxt[s] = pts_pkg::ST_IDLE;
            end
          end
          default: state_nxt[s] = pts_pkg::ST_IDLE;
        endcase
      end
      start_nxt[s] = state_nxt[s] != pts_pkg::ST_IDLE;
      trip_nxt[s]  = state_nxt[s] == pts_pkg::ST_TRIPPED;
    end
    events = {trip_nxt & ~trip_r, start_nxt & ~start_r};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= '0;
      trip_r  <= '0;
      for (int s = 0; s < NS; s++) begin
        state_r[s] <= pts_pkg::ST_IDLE;
        elap_r[s]  <= 16'h0;
      end
    end else begin
      start_r <= start_nxt;
      trip_r  <= trip_nxt;
      for (int s = 0; s < NS; s++) begin
        state_r[s] <= state_nxt[s];
        elap_r[s]  <= elap_nxt[s];
      end
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign stage_start = start_r;
  assign stage_trip  = trip_r;
  assign irq         = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence access_wait_s;
    psel && penable && !pready_r;
  endsequence
  sequence answer_s;
    pready_r ##1 !pready_r;
  endsequence
  apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_wait_s |=> answer_s)
    else $error("APB answer not one wait state");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_r == |(status_r & mask_r))
    else $error("Interrupt level does not follow status and mask");
  for (genvar s = 0; s < NS; s++) begin : g_chk
    disabled_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !en[s] |=> !start_r[s] && !trip_r[s])
      else $error("Disabled stage is active");
    trip_needs_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      trip_r[s] |-> start_r[s])
      else $error("Trip without start");
    hold_between_ticks_a: assert property (@(posedge pclk) disable iff (!presetn)
      (en[s] && !eval_now[s]) |=> $stable(start_r[s]) && $stable(trip_r[s]))
      else $error("Stage changed outside its evaluation tick");
    over_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (en[s] && eval_now[s] && mode[s] == pts_pkg::OVER_MODE && va[s] > lim[s])
      |=> start_r[s])
      else $error("Over mode did not start");
    under_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
      (eval_now[s] && mode[s] == pts_pkg::UNDER_MODE && va[s] < flo[s])
      |=> !start_r[s])
      else $error("Under mode started below floor");
    absolute_difference_mode_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (en[s] && eval_now[s] && mode[s] == pts_pkg::ABSOLUTE_DIFFERENCE_MODE
       && (vd[s] > lim[s] || -vd[s] > lim[s])) |=> start_r[s])
      else $error("Absolute difference did not start");
    diff_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
      (eval_now[s] && mode[s] == pts_pkg::DIFF_MODE && vd[s] <= 18'sh0)
      |=> !start_r[s])
      else $error("Signed difference started on non-positive difference");
    hyst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (en[s] && eval_now[s] && start_r[s] && mode[s] == pts_pkg::OVER_MODE
       && va[s] > lim[s] - hys[s]) |=> start_r[s])
      else $error("Released inside dead band");
  end

endmodule

// ---- dv/pts_meas_model.sv ----
`timescale 1ns/100ps

// Measurement subsystem stand-in: one value per selectable signal, updated on request
module pts_meas_model (
  input  wire logic                                       pclk,
  input  wire logic                                       upd,
  input  wire logic [5:0]                                 idx,
  input  wire logic [15:0]                                val,
  output logic      [pts_pkg::NMEAS-1:0][pts_pkg::VW-1:0] meas_value,
  output logic      [pts_pkg::NVAI-1:0][pts_pkg::VW-1:0]  virtual_analog_input
);

  logic [pts_pkg::NSIG-1:0][15:0] sig_r;

  initial sig_r = '0;

  // Values hold between updates, as a measurement does between refreshes
  always @(posedge pclk) begin
    if (upd && idx < 6'(pts_pkg::NSIG)) begin
      sig_r[idx] <= val;
    end
  end

  assign meas_value           = sig_r[pts_pkg::NMEAS-1:0];
  assign virtual_analog_input = sig_r[pts_pkg::NSIG-1:pts_pkg::NMEAS];

endmodule

// ---- dv/pts_top_tb.sv ----
`timescale 1ns/100ps

module pts_top_tb;

  localparam int TICK = 20;

  logic                                       pclk;
  logic                                       presetn;
  logic                                       psel;
  logic                                       penable;
  logic                                       pwrite;
  logic [11:0]                                paddr;
  logic [31:0]                                pwdata;
  logic [31:0]                                prdata;
  logic                                       pready;
  logic                                       pslverr;
  logic [pts_pkg::NMEAS-1:0][pts_pkg::VW-1:0] meas_value;
  logic [pts_pkg::NVAI-1:0][pts_pkg::VW-1:0]  virtual_analog_input;
  logic [7:0]                                 stage_start;
  logic [7:0]                                 stage_trip;
  logic                                       irq;
  logic                                       upd;
  logic [5:0]                                 idx;
  logic [15:0]                                val;
  logic [31:0]                                rd;
  logic                                       err;
  int                                         failures;
  int                                         num_checks;
  int                                         cyc;
  int                                         n;

  pts_top #(.BASE_TICK_CYC(TICK)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_value(meas_value), .virtual_analog_input(virtual_analog_input),
    .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq)
  );

  pts_meas_model u_meas (
    .pclk(pclk), .upd(upd), .idx(idx), .val(val),
    .meas_value(meas_value), .virtual_analog_input(virtual_analog_input)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Whole run needs about 1200 cycles; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("Error at %0t: no APB answer", $time);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] sa(input int s, input int g, input int w);
    return 12'(pts_pkg::SET_BASE + s * 128 + g * 32 + w * 4);
  endfunction

  task automatic cfg(input int s, input logic [15:0] lim, input logic [15:0] hys,
                     input logic [15:0] dly, input logic [15:0] flr, input logic [31:0] ctl);
    xfer(1'b1, sa(s, 0, 1), {16'h0000, lim});
    xfer(1'b1, sa(s, 0, 2), {16'h0000, hys});
    xfer(1'b1, sa(s, 0, 3), {16'h0000, dly});
    xfer(1'b1, sa(s, 0, 4), {16'h0000, flr});
    xfer(1'b1, sa(s, 0, 0), ctl);
  endtask

  task automatic set_sig(input logic [5:0] i, input logic [15:0] v);
    @(posedge pclk);
    upd <= 1'b1;
    idx <= i;
    val <= v;
    @(posedge pclk);
    upd <= 1'b0;
  endtask

  task automatic ticks(input int k);
    repeat (k * TICK + 2) @(posedge pclk);
  endtask

  // Bounded wait for a stage to start; running out counts as a mismatch
  task automatic wait_start(input int s);
    n = 0;
    while (stage_start[s] !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (stage_start[s] !== 1'b1) begin
      failures++;
      $display("Error at %0t: stage %0d never started", $time, s);
    end
  endtask

  task automatic outs(input logic [7:0] es, input logic [7:0] et, input string what);
    chk({16'h0000, stage_trip, stage_start}, {16'h0000, et, es}, what);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; upd = 1'b0; idx = 6'h00; val = 16'h0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, pts_pkg::ADDR_GROUP, 32'h0);
    chk(rd, 32'h0, "group reset");
    xfer(1'b0, pts_pkg::ADDR_IRQ_MSK, 32'h0);
    chk(rd, 32'h0, "mask reset");
    xfer(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read error");
    xfer(1'b1, pts_pkg::ADDR_IRQ_MSK, 32'h0000_0001);
    // Over mode with dead band and 30 ms delay on a 10 ms period
    cfg(0, 16'h0064, 16'h0014, 16'h001e, 16'h0000, 32'h0000_0001);
    set_sig(6'h00, 16'h0096);
    ticks(2);
    outs(8'h01, 8'h00, "over start before delay");
    chk({31'h0, irq}, 32'h1, "irq on unmasked start");
    ticks(4);
    outs(8'h01, 8'h01, "over trip after delay");
    set_sig(6'h00, 16'h005a);
    ticks(2);
    outs(8'h01, 8'h01, "held inside dead band");
    set_sig(6'h00, 16'h0046);
    ticks(2);
    outs(8'h00, 8'h00, "release past dead band");
    xfer(1'b0, pts_pkg::ADDR_IRQ_ST, 32'h0);
    chk(rd, 32'h0000_0101, "event status");
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    // Under mode: below floor is ignored, between floor and limit starts
    cfg(1, 16'h0064, 16'h0000, 16'h0000, 16'h0032, 32'h0000_0103);
    ticks(2);
    outs(8'h00, 8'h00, "under below floor");
    set_sig(6'h01, 16'h0050);
    ticks(2);
    outs(8'h02, 8'h02, "under start");
    set_sig(6'h01, 16'h00c8);
    // Floor has no effect in over mode
    cfg(6, 16'h0064, 16'h0000, 16'h0000, 16'h01f4, 32'h0000_0601);
    set_sig(6'h06, 16'h0096);
    ticks(2);
    outs(8'h40, 8'h40, "over ignores floor");
    chk({31'h0, irq}, 32'h0, "masked events keep irq low");
    // Difference modes; stage 4 stays disabled on a true condition
    cfg(2, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 32'h0003_0205);
    cfg(3, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 32'h0003_0207);
    cfg(4, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 32'h0000_0200);
    set_sig(6'h03, 16'h00c8);
    ticks(2);
    outs(8'h44, 8'h44, "negative difference");
    set_sig(6'h02, 16'h0190);
    ticks(2);
    outs(8'h4c, 8'h4c, "positive difference");
    // Virtual analog input as supervised signal
    cfg(5, 16'h000a, 16'h0000, 16'h0000, 16'h0000, 32'h0000_2b01);
    set_sig(6'h2b, 16'h0032);
    ticks(2);
    outs(8'h6c, 8'h6c, "virtual input start");
    // 100 ms period: trip one slow period after start
    cfg(7, 16'h000a, 16'h0000, 16'h0064, 16'h0000, 32'h0000_0719);
    set_sig(6'h07, 16'h0032);
    wait_start(7);
    repeat (190) @(posedge pclk);
    outs(8'hec, 8'h6c, "slow period before trip");
    repeat (15) @(posedge pclk);
    outs(8'hec, 8'hec, "slow period trip");
    xfer(1'b0, pts_pkg::ADDR_STATE, 32'h0);
    chk(rd, 32'h0000_ecec, "state register");
    // Group 1: stage 0 has a negative limit on an unsigned signal, so it is clamped;
    // stage 1 watches a signed signal in over mode, 20 ms period, secondary left set
    xfer(1'b1, sa(0, 1, 1), 32'h0000_ff9c);
    xfer(1'b1, sa(0, 1, 0), 32'h0000_0801);
    xfer(1'b1, sa(1, 1, 1), 32'h0000_ff9c);
    xfer(1'b1, sa(1, 1, 3), 32'h0000_000a);
    xfer(1'b1, sa(1, 1, 0), 32'h0002_0a09);
    xfer(1'b1, pts_pkg::ADDR_GROUP, 32'h0000_0001);
    wait_start(1);
    outs(8'h02, 8'h00, "group switch");
    repeat (30) @(posedge pclk);
    outs(8'h02, 8'h00, "20 ms period before trip");
    repeat (15) @(posedge pclk);
    outs(8'h02, 8'h02, "20 ms period trip");
    end_of_test();
  end

endmodule
